// [rtc_regs.svh]
// Register addresses, field positions, reset values and timing for the RTC.
`ifndef RTC_TIME_REGS_SVH
`define RTC_TIME_REGS_SVH

// ----------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------
`define RTC_ADDR_SECONDS 8'h04
`define RTC_ADDR_MINUTES 8'h05
`define RTC_ADDR_HOURS 8'h06
`define RTC_ADDR_DAYS 8'h07
`define RTC_ADDR_WEEKDAYS 8'h08
`define RTC_ADDR_MONTHS 8'h09
`define RTC_ADDR_YEARS 8'h0a

// ----------------------------------------------------------------------
// Field positions and masks
// ----------------------------------------------------------------------
`define RTC_OSC_FLAG_BIT 7
`define RTC_PM_BIT 5
`define RTC_SEC_MASK 8'h7f
`define RTC_MIN_MASK 8'h7f
`define RTC_HOUR24_MASK 8'h3f
`define RTC_HOUR12_MASK 8'h1f
`define RTC_DAY_MASK 8'h3f
`define RTC_WDAY_MASK 8'h07
`define RTC_MONTH_MASK 8'h1f
`define RTC_YEAR_MASK 8'hff

// ----------------------------------------------------------------------
// Reset values and range limits (BCD)
// ----------------------------------------------------------------------
`define RTC_RST_SECONDS 8'h00
`define RTC_RST_MINUTES 8'h00
`define RTC_RST_HOURS 8'h00
`define RTC_RST_DAYS 8'h01
`define RTC_RST_WEEKDAY 8'h06
`define RTC_RST_MONTH 8'h01
`define RTC_RST_YEAR 8'h00
`define RTC_MAX_SEC_MIN 8'h59
`define RTC_MAX_HOUR24 8'h23
`define RTC_HOUR12_NOON 8'h12
`define RTC_HOUR12_LAST 8'h11
`define RTC_FIRST_DAY 8'h01
`define RTC_MAX_WEEKDAY 8'h06
`define RTC_MONTH_FEB 8'h02
`define RTC_MONTH_DEC 8'h12
`define RTC_MAX_YEAR 8'h99
`define RTC_BCD_NINE 4'h9

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define RTC_CLK_PERIOD_NS 25
`define RTC_OSC_STOP_TIME_NS 100000
`define RTC_OSC_EDGES_PER_SEC 32768
`define RTC_OSC_STABLE_EDGES 8192

`endif

// [rtc_pkg.sv]
// Types shared by the RTC time and date counter block.
package rtc_pkg;

    typedef logic [7:0] rtc_byte_t;

    typedef enum logic {
        RTC_TICK_IDLE,
        RTC_TICK_HELD
    } rtc_tick_state_t;

endpackage

// [rtc_sync3.sv]
// Three-stage synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/100ps
module rtc_sync3 (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    // Asynchronous input and synchronised level
    input wire logic async_i,
    output logic level_o
);

    logic meta_reg;
    logic stage2_reg;
    logic stage3_reg;

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            meta_reg <= 1'b0;
            stage2_reg <= 1'b0;
            stage3_reg <= 1'b0;
        end else begin
            meta_reg <= async_i;
            stage2_reg <= meta_reg;
            stage3_reg <= stage2_reg;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            level_o <= 1'b0;
        end else if (stage2_reg == stage3_reg) begin
            level_o <= stage3_reg;
        end
    end

endmodule

// [rtc_osc_monitor.sv]
// Crystal monitor: start-up qualification, stop detection and 1 Hz tick.
`timescale 1ns/100ps
`include "rtc_regs.svh"
module rtc_osc_monitor #(
    parameter int STOP_CYCLES = (`RTC_OSC_STOP_TIME_NS + `RTC_CLK_PERIOD_NS
        - 1) / `RTC_CLK_PERIOD_NS,
    parameter int STABLE_EDGES = `RTC_OSC_STABLE_EDGES,
    parameter int EDGES_PER_SEC = `RTC_OSC_EDGES_PER_SEC
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    // Synchronised crystal level
    input wire logic osc_level_i,
    // Status and tick
    output logic osc_running_o,
    output logic tick_1hz_o
);

    localparam int WD_W = $clog2(STOP_CYCLES + 1);
    localparam int ST_W = $clog2(STABLE_EDGES + 1);
    localparam int PS_W = $clog2(EDGES_PER_SEC + 1);

    if (STOP_CYCLES < 2 || STABLE_EDGES < 1 || EDGES_PER_SEC < 2) begin : g_chk
        $error("rtc_osc_monitor: counts too small");
    end

    logic level_d_reg;
    logic rise;
    logic [WD_W-1:0] wd_reg;
    logic [ST_W-1:0] stable_reg;
    logic [PS_W-1:0] presc_reg;
    logic stopped;

    assign rise = osc_level_i & ~level_d_reg;
    assign stopped = (wd_reg == WD_W'(STOP_CYCLES));

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            level_d_reg <= 1'b0;
        end else begin
            level_d_reg <= osc_level_i;
        end
    end

    // A missing edge for longer than the stop time means the crystal halted.
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wd_reg <= '0;
        end else if (rise) begin
            wd_reg <= '0;
        end else if (!stopped) begin
            wd_reg <= wd_reg + WD_W'(1);
        end
    end

    // Running only after a long unbroken run of edges since reset or the last stop.
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            stable_reg <= '0;
            osc_running_o <= 1'b0;
        end else if (stopped) begin
            stable_reg <= '0;
            osc_running_o <= 1'b0;
        end else if (rise && stable_reg != ST_W'(STABLE_EDGES)) begin
            stable_reg <= stable_reg + ST_W'(1);
        end else if (stable_reg == ST_W'(STABLE_EDGES)) begin
            osc_running_o <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            presc_reg <= '0;
            tick_1hz_o <= 1'b0;
        end else begin
            tick_1hz_o <= 1'b0;
            if (!osc_running_o) begin
                presc_reg <= '0;
            end else if (rise) begin
                if (presc_reg == PS_W'(EDGES_PER_SEC - 1)) begin
                    presc_reg <= '0;
                    tick_1hz_o <= 1'b1;
                end else begin
                    presc_reg <= presc_reg + PS_W'(1);
                end
            end
        end
    end

endmodule

// [rtc_time_counters.sv]
// Clock and calendar counter registers of the real-time clock.
`timescale 1ns/100ps
`include "rtc_regs.svh"
module rtc_time_counters
    import rtc_pkg::*;
#(
    parameter int STOP_CYCLES = (`RTC_OSC_STOP_TIME_NS + `RTC_CLK_PERIOD_NS
        - 1) / `RTC_CLK_PERIOD_NS,
    parameter int STABLE_EDGES = `RTC_OSC_STABLE_EDGES,
    parameter int EDGES_PER_SEC = `RTC_OSC_EDGES_PER_SEC
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    // Crystal oscillator output, asynchronous to the system clock
    input wire logic osc_clk_i,
    // Hour format selection from the control register
    input wire logic mode_12h_i,
    // Register port from the serial bus logic
    input wire logic access_active_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_rd_i,
    output rtc_byte_t reg_rdata_o,
    // Status
    output logic osc_halt_flag_o,
    output logic second_tick_o
);

    // ------------------------------------------------------------------
    // BCD helpers
    // ------------------------------------------------------------------
    function automatic rtc_byte_t bcd_inc(input rtc_byte_t v);
        if (v[3:0] >= `RTC_BCD_NINE) begin
            bcd_inc = {v[7:4] + 4'h1, 4'h0};
        end else begin
            bcd_inc = {v[7:4], v[3:0] + 4'h1};
        end
    endfunction

    function automatic logic leap_year(input rtc_byte_t y);
        // A BCD value is a multiple of four when the units follow the tens
        // parity: even tens with 0/4/8, odd tens with 2/6.
        if (y[4]) begin
            leap_year = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
        end else begin
            leap_year = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) ||
                (y[3:0] == 4'h8);
        end
    endfunction

    function automatic rtc_byte_t last_day(input rtc_byte_t m,
                                           input rtc_byte_t y);
        case (m)
            8'h02: last_day = leap_year(y) ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: last_day = 8'h30;
            default: last_day = 8'h31;
        endcase
    endfunction

    // ------------------------------------------------------------------
    // Oscillator supervision
    // ------------------------------------------------------------------
    logic osc_level;
    logic osc_running;
    logic tick_1hz;

    rtc_sync3 u_osc_sync (
        .clk_sys_i(clk_sys_i),
        .rstn_i(rstn_i),
        .async_i(osc_clk_i),
        .level_o(osc_level)
    );

    rtc_osc_monitor #(
        .STOP_CYCLES(STOP_CYCLES),
        .STABLE_EDGES(STABLE_EDGES),
        .EDGES_PER_SEC(EDGES_PER_SEC)
    ) u_osc_mon (
        .clk_sys_i(clk_sys_i),
        .rstn_i(rstn_i),
        .osc_level_i(osc_level),
        .osc_running_o(osc_running),
        .tick_1hz_o(tick_1hz)
    );

    // ------------------------------------------------------------------
    // Registers and write strobes
    // ------------------------------------------------------------------
    rtc_byte_t sec_reg;
    rtc_byte_t min_reg;
    rtc_byte_t hour_reg;
    rtc_byte_t day_reg;
    rtc_byte_t wday_reg;
    rtc_byte_t month_reg;
    rtc_byte_t year_reg;
    logic osc_flag_reg;

    logic wr_sec;
    logic wr_min;
    logic wr_hour;
    logic wr_day;
    logic wr_wday;
    logic wr_month;
    logic wr_year;

    assign wr_sec = reg_wr_i && (reg_addr_i == `RTC_ADDR_SECONDS);
    assign wr_min = reg_wr_i && (reg_addr_i == `RTC_ADDR_MINUTES);
    assign wr_hour = reg_wr_i && (reg_addr_i == `RTC_ADDR_HOURS);
    assign wr_day = reg_wr_i && (reg_addr_i == `RTC_ADDR_DAYS);
    assign wr_wday = reg_wr_i && (reg_addr_i == `RTC_ADDR_WEEKDAYS);
    assign wr_month = reg_wr_i && (reg_addr_i == `RTC_ADDR_MONTHS);
    assign wr_year = reg_wr_i && (reg_addr_i == `RTC_ADDR_YEARS);

    // ------------------------------------------------------------------
    // Tick holding while an access is in progress
    // ------------------------------------------------------------------
    rtc_tick_state_t tick_state_reg;
    logic can_apply;
    logic advance;

    // A write in the same cycle also defers the tick, so a write is never
    // overwritten by a carry computed from the old contents.
    assign can_apply = !access_active_i && !reg_wr_i;
    assign advance = can_apply &&
        (tick_1hz || tick_state_reg == RTC_TICK_HELD);
    assign second_tick_o = advance;

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tick_state_reg <= RTC_TICK_IDLE;
        end else begin
            case (tick_state_reg)
                RTC_TICK_IDLE: begin
                    if (tick_1hz && !can_apply) begin
                        tick_state_reg <= RTC_TICK_HELD;
                    end
                end
                RTC_TICK_HELD: begin
                    // Only one tick can wait; a second one while held is lost.
                    if (can_apply && !tick_1hz) begin
                        tick_state_reg <= RTC_TICK_IDLE;
                    end
                end
                default: tick_state_reg <= RTC_TICK_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Carry chain
    // ------------------------------------------------------------------
    rtc_byte_t sec_next;
    rtc_byte_t min_next;
    rtc_byte_t hour_next;
    rtc_byte_t day_next;
    rtc_byte_t wday_next;
    rtc_byte_t month_next;
    rtc_byte_t year_next;
    logic carry_min;
    logic carry_hour;
    logic carry_day;
    logic carry_month;
    logic carry_year;

    always_comb begin
        carry_min = (sec_reg >= `RTC_MAX_SEC_MIN);
        sec_next = carry_min ? 8'h00 : bcd_inc(sec_reg);
        carry_hour = carry_min && (min_reg >= `RTC_MAX_SEC_MIN);
        min_next = min_reg;
        if (carry_min) begin
            min_next = (min_reg >= `RTC_MAX_SEC_MIN) ? 8'h00 :
                bcd_inc(min_reg);
        end
    end

    always_comb begin
        hour_next = hour_reg;
        carry_day = 1'b0;
        if (carry_hour) begin
            if (mode_12h_i) begin
                // Twelve o'clock follows eleven and flips the half of day;
                // one o'clock follows twelve without flipping it.
                if (hour_reg[4:0] == `RTC_HOUR12_NOON) begin
                    hour_next = {hour_reg[7:5], 5'h01};
                end else if (hour_reg[4:0] == `RTC_HOUR12_LAST) begin
                    hour_next = {2'b00, ~hour_reg[`RTC_PM_BIT],
                        5'(`RTC_HOUR12_NOON)};
                    carry_day = hour_reg[`RTC_PM_BIT];
                end else begin
                    hour_next = {2'b00, hour_reg[`RTC_PM_BIT],
                        5'(bcd_inc(hour_reg & `RTC_HOUR12_MASK))};
                end
            end else begin
                if (hour_reg >= `RTC_MAX_HOUR24) begin
                    hour_next = 8'h00;
                    carry_day = 1'b1;
                end else begin
                    hour_next = bcd_inc(hour_reg);
                end
            end
        end
    end

    always_comb begin
        day_next = day_reg;
        wday_next = wday_reg;
        carry_month = 1'b0;
        if (carry_day) begin
            if (day_reg >= last_day(month_reg, year_reg)) begin
                day_next = `RTC_FIRST_DAY;
                carry_month = 1'b1;
            end else begin
                day_next = bcd_inc(day_reg);
            end
            wday_next = (wday_reg >= `RTC_MAX_WEEKDAY) ? 8'h00 :
                wday_reg + 8'h01;
        end
    end

    always_comb begin
        month_next = month_reg;
        year_next = year_reg;
        carry_year = carry_month && (month_reg >= `RTC_MONTH_DEC);
        if (carry_month) begin
            month_next = carry_year ? `RTC_RST_MONTH :
                bcd_inc(month_reg);
        end
        if (carry_year) begin
            year_next = (year_reg >= `RTC_MAX_YEAR) ? 8'h00 :
                bcd_inc(year_reg);
        end
    end

    // ------------------------------------------------------------------
    // Seconds and oscillator halt flag
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sec_reg <= `RTC_RST_SECONDS;
        end else if (wr_sec) begin
            sec_reg <= reg_wdata_i & `RTC_SEC_MASK;
        end else if (advance) begin
            sec_reg <= sec_next;
        end
    end

    // A halted oscillator wins over a clear in the same cycle, so software
    // can only see the flag at zero once the crystal really runs.
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            osc_flag_reg <= 1'b1;
        end else if (!osc_running) begin
            osc_flag_reg <= 1'b1;
        end else if (wr_sec) begin
            osc_flag_reg <= reg_wdata_i[`RTC_OSC_FLAG_BIT];
        end
    end

    assign osc_halt_flag_o = osc_flag_reg;

    // ------------------------------------------------------------------
    // Minutes, hours, day and weekday
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            min_reg <= `RTC_RST_MINUTES;
        end else if (wr_min) begin
            min_reg <= reg_wdata_i & `RTC_MIN_MASK;
        end else if (advance) begin
            min_reg <= min_next;
        end
    end

    // The stored bits are the same in both formats; switching format does
    // not convert the count, so software rewrites the hours after a switch.
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            hour_reg <= `RTC_RST_HOURS;
        end else if (wr_hour) begin
            hour_reg <= reg_wdata_i & `RTC_HOUR24_MASK;
        end else if (advance) begin
            hour_reg <= hour_next;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            day_reg <= `RTC_RST_DAYS;
        end else if (wr_day) begin
            day_reg <= reg_wdata_i & `RTC_DAY_MASK;
        end else if (advance) begin
            day_reg <= day_next;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wday_reg <= `RTC_RST_WEEKDAY;
        end else if (wr_wday) begin
            wday_reg <= reg_wdata_i & `RTC_WDAY_MASK;
        end else if (advance) begin
            wday_reg <= wday_next;
        end
    end

    // ------------------------------------------------------------------
    // Month and year
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            month_reg <= `RTC_RST_MONTH;
        end else if (wr_month) begin
            month_reg <= reg_wdata_i & `RTC_MONTH_MASK;
        end else if (advance) begin
            month_reg <= month_next;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            year_reg <= `RTC_RST_YEAR;
        end else if (wr_year) begin
            year_reg <= reg_wdata_i & `RTC_YEAR_MASK;
        end else if (advance) begin
            year_reg <= year_next;
        end
    end

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                `RTC_ADDR_SECONDS:
                    reg_rdata_o <= {osc_flag_reg, sec_reg[6:0]};
                `RTC_ADDR_MINUTES: reg_rdata_o <= min_reg;
                `RTC_ADDR_HOURS: reg_rdata_o <= hour_reg;
                `RTC_ADDR_DAYS: reg_rdata_o <= day_reg;
                `RTC_ADDR_WEEKDAYS: reg_rdata_o <= wday_reg;
                `RTC_ADDR_MONTHS: reg_rdata_o <= month_reg;
                `RTC_ADDR_YEARS: reg_rdata_o <= year_reg;
                default: reg_rdata_o <= 8'h00;
            endcase
        end
    end

endmodule

// [rtc_counters_properties.sv]
// Port-level assertions for the RTC time and date counter block.
`timescale 1ns/100ps
module rtc_counters_chk
    import rtc_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    input wire logic access_active_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_rd_i,
    input wire rtc_byte_t reg_rdata_o,
    input wire logic osc_halt_flag_o,
    input wire logic second_tick_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);
    logic rd4;
    logic clr4;
    assign rd4 = reg_rd_i && reg_addr_i == 8'h04;
    assign clr4 = reg_wr_i && reg_addr_i == 8'h04 && !reg_wdata_i[7];
    property p_freeze;
        second_tick_o |-> !access_active_i && !reg_wr_i;
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("tick during an access");
    property p_rst_flag;
        $rose(rstn_i) |-> osc_halt_flag_o;
    endproperty
    a_rst_flag: assert property (p_rst_flag)
        else $error("halt flag clear after reset");
    property p_keep;
        osc_halt_flag_o && !clr4 |=> osc_halt_flag_o;
    endproperty
    a_keep: assert property (p_keep)
        else $error("halt flag dropped without a clear");
    property p_flag_rd;
        rd4 && !reg_wr_i |=> reg_rdata_o[7] == $past(osc_halt_flag_o);
    endproperty
    a_flag_rd: assert property (p_flag_rd)
        else $error("seconds bit 7 differs from flag");
    property p_sec;
        rd4 |=> reg_rdata_o[6:4] <= 3'h5 && reg_rdata_o[3:0] <= 4'h9;
    endproperty
    a_sec: assert property (p_sec)
        else $error("seconds out of range");
    property p_min;
        reg_rd_i && reg_addr_i == 8'h05 |=> !reg_rdata_o[7];
    endproperty
    a_min: assert property (p_min)
        else $error("minutes bit 7 set");
    property p_hr;
        reg_rd_i && reg_addr_i == 8'h06 |=> reg_rdata_o[7:6] == 2'h0;
    endproperty
    a_hr: assert property (p_hr)
        else $error("hours bits 7 to 6 set");
    property p_wday;
        reg_rd_i && reg_addr_i == 8'h08 |=> reg_rdata_o <= 8'h06;
    endproperty
    a_wday: assert property (p_wday)
        else $error("weekday out of range");
    property p_unmap;
        reg_rd_i && reg_addr_i > 8'h0a |=> reg_rdata_o == 8'h00;
    endproperty
    a_unmap: assert property (p_unmap)
        else $error("unmapped read not zero");
    c_tick: cover property (second_tick_o);
    c_clear: cover property ($fell(osc_halt_flag_o));
    c_held: cover property (access_active_i ##1 second_tick_o);
endmodule
bind rtc_time_counters rtc_counters_chk u_chk (.clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i), .access_active_i(access_active_i),
    .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .osc_halt_flag_o(osc_halt_flag_o),
    .second_tick_o(second_tick_o));

// [rtc_host_model.sv]
// Bus host stand-in that drives the counter block's register port.
`timescale 1ns/100ps
module rtc_host_model
    import rtc_pkg::*;
(
    input wire logic clk_sys_i,
    input wire rtc_byte_t rdata_i,
    output logic acc_o,
    output rtc_byte_t addr_o,
    output logic wr_o,
    output rtc_byte_t wdata_o,
    output logic rd_o
);
    initial begin
        acc_o = 1'b0;
        addr_o = 8'h00;
        wr_o = 1'b0;
        wdata_o = 8'hff;
        rd_o = 1'b0;
    end
    // Callers keep each access under a second unless testing a lost tick.
    task automatic acc(input logic on);
        @(negedge clk_sys_i);
        acc_o = on;
    endtask
    task automatic wr(input rtc_byte_t a, input rtc_byte_t d);
        @(negedge clk_sys_i);
        addr_o = a;
        wdata_o = d;
        wr_o = 1'b1;
        @(negedge clk_sys_i);
        wr_o = 1'b0;
        wdata_o = ~d;
    endtask
    task automatic rd(input rtc_byte_t a, output rtc_byte_t d);
        @(negedge clk_sys_i);
        addr_o = a;
        rd_o = 1'b1;
        @(negedge clk_sys_i);
        rd_o = 1'b0;
        d = rdata_i;
    endtask
endmodule

// [rtc_time_date_counters_tb_top.sv]
// Self-checking bench for the RTC time and date counters.
`timescale 1ns/100ps
module rtc_time_date_counters_tb_top
    import rtc_pkg::*;
;
    logic clk_sys_i;
    logic rstn_i;
    logic osc;
    logic osc_en = 1'b0;
    logic m12;
    logic acc, wr, rd, flag, tick;
    rtc_byte_t addr, wdata, rdata, v;
    int n_fail = 0;
    int check_count = 0;
    int seed = 62324;
    int n_ticks = 0;
    int t0, s, mi, h, d, wd, mo, y, fl;
    int cs[8][8] = '{'{0, 0, 0, 1, 6, 1, 0, 0}, '{59, 59, 13, 15, 3, 6, 24, 1},
        '{59, 59, 23, 28, 6, 2, 4, 0}, '{59, 59, 23, 28, 6, 2, 3, 0},
        '{59, 59, 23, 31, 2, 12, 99, 1}, '{59, 59, 11, 29, 1, 2, 0, 1},
        '{59, 59, 23, 29, 1, 2, 0, 0}, '{59, 59, 23, 30, 3, 4, 21, 0}};
    always #12.5 clk_sys_i = ~clk_sys_i;
    always #100 osc = osc_en ? ~osc : osc;
    always @(posedge clk_sys_i) n_ticks += (tick === 1'b1);
    rtc_time_counters #(.STOP_CYCLES(24), .STABLE_EDGES(4),
        .EDGES_PER_SEC(4)) dut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
        .osc_clk_i(osc), .mode_12h_i(m12), .access_active_i(acc),
        .reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wdata),
        .reg_rd_i(rd), .reg_rdata_o(rdata), .osc_halt_flag_o(flag),
        .second_tick_o(tick));
    rtc_host_model host (.clk_sys_i(clk_sys_i), .rdata_i(rdata),
        .acc_o(acc), .addr_o(addr), .wr_o(wr), .wdata_o(wdata), .rd_o(rd));
    function automatic rtc_byte_t bcd(input int x);
        return rtc_byte_t'(((x / 10) << 4) + x % 10);
    endfunction
    function automatic rtc_byte_t exp_reg(input int i);
        case (i)
            0: return bcd(s) | rtc_byte_t'(fl << 7);
            1: return bcd(mi);
            2: return !m12 ? bcd(h) : h == 0 ? 8'h12 : h < 12 ? bcd(h)
                : h == 12 ? 8'h32 : 8'h20 | bcd(h - 12);
            3: return bcd(d);
            4: return rtc_byte_t'(wd);
            5: return bcd(mo);
            default: return bcd(y);
        endcase
    endfunction
    task automatic step();
        int ml;
        ml = mo == 2 ? (y % 4 == 0 ? 29 : 28) : mo inside {4, 6, 9, 11}
            ? 30 : 31;
        s = (s + 1) % 60;
        if (s == 0) mi = (mi + 1) % 60;
        if (s == 0 && mi == 0) h = (h + 1) % 24;
        if (s == 0 && mi == 0 && h == 0) begin
            wd = (wd + 1) % 7;
            d = d % ml + 1;
            if (d == 1) mo = mo % 12 + 1;
            if (d == 1 && mo == 1) y = (y + 1) % 100;
        end
    endtask
    task automatic load(input int r);
        s = cs[r][0];
        mi = cs[r][1];
        h = cs[r][2];
        d = cs[r][3];
        wd = cs[r][4];
        mo = cs[r][5];
        y = cs[r][6];
        m12 = cs[r][7][0];
    endtask
    task automatic chk(input rtc_byte_t seen, input rtc_byte_t want);
        check_count++;
        if (seen !== want) begin
            n_fail++;
            $display("[ERR] %0t got %h want %h", $time, seen, want);
        end
    endtask
    // Ticks seen before the freeze took hold are replayed on the model.
    task automatic read_all();
        host.acc(1'b1);
        @(negedge clk_sys_i);
        repeat (n_ticks - t0) step();
        for (int i = 0; i < 7; i++) begin
            host.rd(rtc_byte_t'(4 + i), v);
            chk(v, exp_reg(i));
        end
        host.acc(1'b0);
    endtask
    task automatic complete_run();
        $display("checks %0d failures %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        repeat (6000) @(posedge clk_sys_i);
        n_fail++;
        complete_run();
    end
    initial begin
        clk_sys_i = 1'b0;
        rstn_i = 1'b0;
        osc = 1'b0;
        fl = 1;
        load(0);
        repeat (12) @(negedge clk_sys_i);
        rstn_i = 1'b1;
        t0 = n_ticks;
        read_all();
        host.rd(8'h0b, v);
        chk(v, 8'h00);
        host.wr(8'h04, 8'h00);
        read_all();
        osc_en = 1'b1;
        repeat (80) @(negedge clk_sys_i);
        host.wr(8'h04, 8'h00);
        host.rd(8'h04, v);
        chk({7'h00, v[7]}, 8'h00);
        fl = 0;
        cs[1][3] = ($random(seed) & 32'h3f) % 28 + 1;
        for (int c = 1; c < 8; c++) begin
            // Align to a tick so both ticks inside the access are known.
            @(posedge clk_sys_i iff tick === 1'b1);
            @(negedge clk_sys_i);
            load(c);
            host.acc(1'b1);
            for (int i = 0; i < 7; i++) host.wr(rtc_byte_t'(4 + i), exp_reg(i));
            // Held past a second on purpose so a second tick is dropped.
            repeat (60) @(negedge clk_sys_i);
            t0 = n_ticks;
            host.acc(1'b0);
            repeat (2) @(negedge clk_sys_i);
            chk(rtc_byte_t'(n_ticks - t0), 8'h01);
            read_all();
        end
        osc_en = 1'b0;
        repeat (60) @(negedge clk_sys_i);
        chk({7'h00, flag}, 8'h01);
        complete_run();
    end
endmodule
